// ===== hdl/usb_link_power_cfg.svh
// constants for the link power configuration fields
`ifndef USB_LINK_POWER_CFG_SVH
`define USB_LINK_POWER_CFG_SVH

`define ULP_ADDR_W          12
`define ULP_DATA_W          32
`define ULP_CFG_ONE_OFFSET  12'h084
`define ULP_STATUS_OFFSET   12'h0fc

`define ULP_U1_INIT_BIT     10
`define ULP_U1_ACCEPT_BIT   9
`define ULP_LTM_BIT         8
`define ULP_FS_CAL_MSB      6
`define ULP_FS_CAL_LSB      4
`define ULP_FS_CAL_W        3

`define ULP_U1_INIT_RST     1'b0
`define ULP_U1_ACCEPT_RST   1'b1
`define ULP_LTM_RST         1'b0
`define ULP_FS_CAL_RST      3'h0
`define ULP_IMAGE_FALLBACK  6'h10

`define ULP_FS_BASE_MIN     16
`define ULP_FS_BASE_MAX     18
`define ULP_FS_TENTHS_60M   2
`define ULP_TENTHS_PER_BIT  10
`define ULP_HS_BASE_BITS    736
`define ULP_HS_BITS_60M     8

`define ULP_ST_SOURCE_EE    0
`define ULP_ST_SOURCE_OTP   1
`define ULP_ST_INIT_OK      2
`define ULP_ST_FS_MODE      3
`define ULP_ST_RESTORED     4
`define ULP_ST_CAL_LSB      8
`define ULP_ST_HS_LSB       12
`define ULP_ST_FS_LSB       24

`endif

// ===== hdl/usb_link_power_pkg.sv
// types for the link power configuration fields
package usb_link_power_pkg;
   typedef enum logic [3:0] {
      ST_HOLD  = 4'b0001,
      ST_LOAD  = 4'b0010,
      ST_APPLY = 4'b0100,
      ST_RUN   = 4'b1000
   } ctl_state_t;
   typedef logic [2:0] fs_cal_t;
endpackage

// ===== hdl/image_default_select.sv
// latches the last loaded configuration image, eeprom before otp before fallback
`timescale 1ns/100ps
module image_default_select #(
   parameter int          W        = 6,
   parameter logic [W-1:0] FALLBACK = '0
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         capture,
   input  wire logic         eepromPresent,
   input  wire logic [W-1:0] eepromImage,
   input  wire logic         otpProgrammed,
   input  wire logic [W-1:0] otpImage,
   output logic      [W-1:0] image,
   output logic              fromEeprom,
   output logic              fromOtp
);
   // priority chain for the image source
   always_ff @(posedge clk) begin
      if (rst) begin
         image      <= FALLBACK;
         fromEeprom <= 1'b0;
         fromOtp    <= 1'b0;
      end else if (capture) begin
         fromEeprom <= eepromPresent;
         fromOtp    <= ~eepromPresent & otpProgrammed;
         if (eepromPresent) begin
            image <= eepromImage;
         end else if (otpProgrammed) begin
            image <= otpImage;
         end else begin
            image <= FALLBACK;
         end
      end
   end
endmodule

// ===== hdl/usb_link_power_cfg_fields.sv
// link power configuration fields: u1, latency tolerance and fs timeout calibration
//
// Behaviour
// - u1 initiation needs this bit and host enable
// - initiation bit independent of accept bit
// - accept bit gates host u1 entry requests
// - accept bit works regardless of initiation bit
// - ltm bit enables latency tolerance messaging
// - protection keeps bits 10:8 over resets
// - fs timeout adds calibration count times factor
// - fs baseline timeout within 16..18 bit times
// - each calibration count adds 0.2 bit times
// - only the 60 MHz factor is built
// - outside fs mode present hs calibration
// - bits 10,8 default image else zero
// - bit 9 default image else one
// - fs calibration default image else zero
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
`include "usb_link_power_cfg.svh"
module usb_link_power_cfg_fields #(
   parameter int FS_BASE_BITS = `ULP_FS_BASE_MIN,
   parameter int HS_BASE_BITS = `ULP_HS_BASE_BITS
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic [`ULP_ADDR_W-1:0] addr,
   input  wire logic [`ULP_DATA_W-1:0] wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [`ULP_DATA_W-1:0] rdata,
   input  wire logic                   eepromPresent,
   input  wire logic                   eepromU1Init,
   input  wire logic                   eepromU1Accept,
   input  wire logic                   eepromLtm,
   input  wire logic [2:0]             eepromFsCal,
   input  wire logic                   otpProgrammed,
   input  wire logic                   otpU1Init,
   input  wire logic                   otpU1Accept,
   input  wire logic                   otpLtm,
   input  wire logic [2:0]             otpFsCal,
   input  wire logic                   imageLoaded,
   input  wire logic                   usbReset,
   input  wire logic                   liteReset,
   input  wire logic                   resetProtect,
   input  wire logic                   hostU1Enable,
   input  wire logic                   hostU1Request,
   input  wire logic                   fsMode,
   input  wire logic [2:0]             hsCal,
   output logic                        u1InitiateAllowed,
   output logic                        u1Ack,
   output logic                        u1Reject,
   output logic                        ltmEnable,
   output logic      [2:0]             coreTimeoutCal,
   output logic      [7:0]             fsTimeoutTenths,
   output logic      [9:0]             hsTimeoutBits,
   output logic                        ready
);
   // baseline outside the legal window falls back to the minimum
   localparam int FS_BASE_OK = (FS_BASE_BITS >= `ULP_FS_BASE_MIN &&
                                FS_BASE_BITS <= `ULP_FS_BASE_MAX) ?
                               FS_BASE_BITS : `ULP_FS_BASE_MIN;
   localparam logic [7:0] FS_BASE_TENTHS =
      8'(FS_BASE_OK * `ULP_TENTHS_PER_BIT);
   // only the 60 MHz phy clock exists, so a single step value is built
   localparam logic [7:0] FS_STEP_TENTHS =
      8'(`ULP_FS_TENTHS_60M);
   // hs figures are whole bit times, fs figures tenths of a bit time
   localparam logic [9:0] HS_BASE = 10'(HS_BASE_BITS);
   localparam logic [9:0] HS_STEP = 10'(`ULP_HS_BITS_60M);

   // start-up sequencer and the stored calibration count
   usb_link_power_pkg::ctl_state_t state;
   usb_link_power_pkg::ctl_state_t next_state;
   usb_link_power_pkg::fs_cal_t    fsCal;

   // stored field bits and the image latch outputs
   logic       u1Init;
   logic       u1Accept;
   logic       ltm;
   logic       restoredSeen;
   logic [5:0] image;
   logic       fromEeprom;
   logic       fromOtp;
   // decode and reload strobes
   logic       capture;
   logic       restore;
   logic       protectHit;
   logic       cfgHit;
   logic       statusHit;
   logic       cfgWrite;
   logic       statusWrite;
   logic       running;
   logic [5:0] eepromImage;
   logic [5:0] otpImage;
   logic [`ULP_DATA_W-1:0] cfgWord;
   logic [`ULP_DATA_W-1:0] statusWord;
   logic [7:0]             next_fsTimeoutTenths;
   logic [9:0]             next_hsTimeoutBits;

   // image layout: init, accept, ltm, fs calibration
   assign eepromImage = {eepromU1Init, eepromU1Accept, eepromLtm, eepromFsCal};
   assign otpImage    = {otpU1Init, otpU1Accept, otpLtm, otpFsCal};

   // capture at start-up and whenever a fresh image has been read in
   assign capture = (state == usb_link_power_pkg::ST_LOAD) | imageLoaded;

   // either bus reset of the link brings the unprotected fields back to the image
   assign restore    = running & (usbReset | liteReset);
   assign protectHit = restore & resetProtect;

   // writes before run are dropped, reads are served from the first cycle
   assign running     = (state == usb_link_power_pkg::ST_RUN);
   assign cfgHit      = (addr == `ULP_CFG_ONE_OFFSET);
   assign statusHit   = (addr == `ULP_STATUS_OFFSET);
   assign cfgWrite    = wr & cfgHit & running;
   assign statusWrite = wr & statusHit & running;

   // the image latch keeps the last loaded values for later restores
   image_default_select #(
      .W        (6),
      .FALLBACK (`ULP_IMAGE_FALLBACK)
   ) u_image (
      .clk           (clk),
      .rst           (rst),
      .capture       (capture),
      .eepromPresent (eepromPresent),
      .eepromImage   (eepromImage),
      .otpProgrammed (otpProgrammed),
      .otpImage      (otpImage),
      .image         (image),
      .fromEeprom    (fromEeprom),
      .fromOtp       (fromOtp)
   );

   // start-up sequence: strap inputs are sampled only after reset release
   always_comb begin
      next_state = state;
      case (state)
         usb_link_power_pkg::ST_HOLD: begin
            next_state = usb_link_power_pkg::ST_LOAD;
         end
         usb_link_power_pkg::ST_LOAD: begin
            next_state = usb_link_power_pkg::ST_APPLY;
         end
         usb_link_power_pkg::ST_APPLY: begin
            next_state = usb_link_power_pkg::ST_RUN;
         end
         usb_link_power_pkg::ST_RUN: begin
            next_state = usb_link_power_pkg::ST_RUN;
         end
         default: begin
            next_state = usb_link_power_pkg::ST_HOLD;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= usb_link_power_pkg::ST_HOLD;
      end else begin
         state <= next_state;
      end
   end

   // u1 initiation enable; an unprotected restore wins over a write in the same cycle
   // a protected reset keeps the software value, a plain one reloads it
   always_ff @(posedge clk) begin
      if (rst) begin
         u1Init <= `ULP_U1_INIT_RST;
      end else if (state == usb_link_power_pkg::ST_APPLY) begin
         u1Init <= image[5];
      end else if (restore & ~protectHit) begin
         u1Init <= image[5];
      end else if (cfgWrite) begin
         u1Init <= wdata[`ULP_U1_INIT_BIT];
      end
   end

   // u1 accept enable, stored apart from the initiation bit
   // defaulting to one keeps host u1 requests working on a blank image
   always_ff @(posedge clk) begin
      if (rst) begin
         u1Accept <= `ULP_U1_ACCEPT_RST;
      end else if (state == usb_link_power_pkg::ST_APPLY) begin
         u1Accept <= image[4];
      end else if (restore & ~protectHit) begin
         u1Accept <= image[4];
      end else if (cfgWrite) begin
         u1Accept <= wdata[`ULP_U1_ACCEPT_BIT];
      end
   end

   // latency tolerance messaging enable
   // protected in the same way as the two u1 bits
   always_ff @(posedge clk) begin
      if (rst) begin
         ltm <= `ULP_LTM_RST;
      end else if (state == usb_link_power_pkg::ST_APPLY) begin
         ltm <= image[3];
      end else if (restore & ~protectHit) begin
         ltm <= image[3];
      end else if (cfgWrite) begin
         ltm <= wdata[`ULP_LTM_BIT];
      end
   end

   // fs calibration is not protected, so every link reset reloads it
   // a write in the same cycle as a reload is lost on purpose
   always_ff @(posedge clk) begin
      if (rst) begin
         fsCal <= `ULP_FS_CAL_RST;
      end else if (state == usb_link_power_pkg::ST_APPLY) begin
         fsCal <= image[2:0];
      end else if (restore) begin
         fsCal <= image[2:0];
      end else if (cfgWrite) begin
         fsCal <= wdata[`ULP_FS_CAL_MSB:`ULP_FS_CAL_LSB];
      end
   end

   // sticky restore flag, write one to clear; a new restore beats the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         restoredSeen <= 1'b0;
      end else if (restore) begin
         restoredSeen <= 1'b1;
      end else if (statusWrite & wdata[`ULP_ST_RESTORED]) begin
         restoredSeen <= 1'b0;
      end
   end

   // register word; bit 7, bits 3:2 and bits outside 10:4 stay zero
   always_comb begin
      cfgWord = '0;
      cfgWord[`ULP_U1_INIT_BIT]   = u1Init;
      cfgWord[`ULP_U1_ACCEPT_BIT] = u1Accept;
      cfgWord[`ULP_LTM_BIT]       = ltm;
      cfgWord[`ULP_FS_CAL_MSB:`ULP_FS_CAL_LSB] = fsCal;
   end

   // status word shows the block's own derived state
   always_comb begin
      statusWord = '0;
      statusWord[`ULP_ST_SOURCE_EE]  = fromEeprom;
      statusWord[`ULP_ST_SOURCE_OTP] = fromOtp;
      statusWord[`ULP_ST_INIT_OK]    = u1InitiateAllowed;
      statusWord[`ULP_ST_FS_MODE]    = fsMode;
      statusWord[`ULP_ST_RESTORED]   = restoredSeen;
      statusWord[`ULP_ST_CAL_LSB+2:`ULP_ST_CAL_LSB] = coreTimeoutCal;
      statusWord[`ULP_ST_HS_LSB+9:`ULP_ST_HS_LSB]   = hsTimeoutBits;
      statusWord[`ULP_ST_FS_LSB+7:`ULP_ST_FS_LSB]   = fsTimeoutTenths;
   end

   // read data stand one cycle after the strobe and are zero otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (rd & cfgHit) begin
         rdata <= cfgWord;
      end else if (rd & statusHit) begin
         rdata <= statusWord;
      end else begin
         rdata <= '0;                                          // unmapped
      end
   end

   // device may start u1 only with both its own bit and the host feature
   always_ff @(posedge clk) begin
      if (rst) begin
         u1InitiateAllowed <= 1'b0;
      end else begin
         u1InitiateAllowed <= u1Init & hostU1Enable;
      end
   end

   // host u1 entry requests are answered from the accept bit alone
   always_ff @(posedge clk) begin
      if (rst) begin
         u1Ack    <= 1'b0;
         u1Reject <= 1'b0;
      end else begin
         u1Ack    <= hostU1Request & u1Accept;
         u1Reject <= hostU1Request & ~u1Accept;
      end
   end

   // ltm follows its bit directly
   always_ff @(posedge clk) begin
      if (rst) begin
         ltmEnable <= 1'b0;
      end else begin
         ltmEnable <= ltm;
      end
   end

   // fs timeout in tenths of a bit time: baseline plus count times 0.2
   // tenths keep the 0.2 step exact; the largest sum still fits in 8 bits
   always_comb begin
      next_fsTimeoutTenths = FS_BASE_TENTHS
                           + 8'(fsCal) * FS_STEP_TENTHS;
   end

   // registered so the core always sees a settled value
   always_ff @(posedge clk) begin
      if (rst) begin
         fsTimeoutTenths <= FS_BASE_TENTHS;
      end else begin
         fsTimeoutTenths <= next_fsTimeoutTenths;
      end
   end

   // hs timeout in bit times at the 60 MHz factor
   always_comb begin
      next_hsTimeoutBits = HS_BASE + 10'(hsCal) * HS_STEP;
   end

   // the hs count comes from outside and is only scaled here
   always_ff @(posedge clk) begin
      if (rst) begin
         hsTimeoutBits <= HS_BASE;
      end else begin
         hsTimeoutBits <= next_hsTimeoutBits;
      end
   end

   // the core sees only one calibration count, picked by link speed
   always_ff @(posedge clk) begin
      if (rst) begin
         coreTimeoutCal <= `ULP_FS_CAL_RST;
      end else if (fsMode) begin
         coreTimeoutCal <= fsCal;
      end else begin
         coreTimeoutCal <= hsCal;
      end
   end

   // writes before this rises are dropped, since the image is still settling
   always_ff @(posedge clk) begin
      if (rst) begin
         ready <= 1'b0;
      end else begin
         ready <= (next_state == usb_link_power_pkg::ST_RUN);
      end
   end
endmodule

// ===== tb/usb_link_power_monitor.sv
// assertions on the ports of the link power configuration block
`timescale 1ns/100ps
module usb_link_power_monitor #(
   parameter int FS_BASE_BITS = 16,
   parameter int HS_BASE_BITS = 736
) (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [11:0] addr,
   input wire logic        rd,
   input wire logic [31:0] rdata,
   input wire logic        hostU1Enable,
   input wire logic        hostU1Request,
   input wire logic        fsMode,
   input wire logic [2:0]  hsCal,
   input wire logic        u1InitiateAllowed,
   input wire logic        u1Ack,
   input wire logic        u1Reject,
   input wire logic        ltmEnable,
   input wire logic [2:0]  coreTimeoutCal,
   input wire logic [7:0]  fsTimeoutTenths,
   input wire logic [9:0]  hsTimeoutBits,
   input wire logic        ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // a config read and the cycle of its answer
   sequence cfg_read;
      rd && addr == 12'h084 ##1 1'b1;
   endsequence
   // derived outputs are one cycle late, so skip the first running cycle
   sequence warm;
      ready ##1 ready;
   endsequence
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
      else $error("read data not idle");
   reserved_zero_a: assert property (cfg_read |-> rdata[31:11] == 21'h0 && !rdata[7] && rdata[3:2] == 2'h0)
      else $error("reserved config bits set");
   ltm_follow_a: assert property (cfg_read |-> ltmEnable == rdata[8])
      else $error("ltm output differs from its bit");
   init_gate_a: assert property (cfg_read |-> u1InitiateAllowed == (rdata[10] & $past(hostU1Enable)))
      else $error("u1 initiation gate wrong");
   u1_answer_a: assert property (hostU1Request |=> u1Ack != u1Reject)
      else $error("u1 request not answered once");
   u1_quiet_a: assert property (!hostU1Request |=> !u1Ack && !u1Reject)
      else $error("u1 answer without request");
   fs_range_a: assert property (fsTimeoutTenths >= 8'(10 * FS_BASE_BITS)
      && fsTimeoutTenths <= 8'(10 * FS_BASE_BITS + 14) && !fsTimeoutTenths[0]) else $error("fs timeout range");
   fs_core_a: assert property (warm ##0 $past(fsMode)
      |-> coreTimeoutCal == 3'((fsTimeoutTenths - 8'(10 * FS_BASE_BITS)) >> 1)) else $error("fs cal mismatch");
   hs_core_a: assert property (warm ##0 !$past(fsMode) |-> coreTimeoutCal == $past(hsCal))
      else $error("hs cal not presented");
   hs_time_a: assert property (warm |-> hsTimeoutBits == 10'(HS_BASE_BITS + 8 * $past(hsCal)))
      else $error("hs timeout wrong");
endmodule
bind usb_link_power_cfg_fields usb_link_power_monitor #(.FS_BASE_BITS(FS_BASE_BITS), .HS_BASE_BITS(HS_BASE_BITS)) mon (
   .clk(clk), .rst(rst), .addr(addr), .rd(rd), .rdata(rdata), .hostU1Enable(hostU1Enable),
   .hostU1Request(hostU1Request), .fsMode(fsMode), .hsCal(hsCal), .u1InitiateAllowed(u1InitiateAllowed),
   .u1Ack(u1Ack), .u1Reject(u1Reject), .ltmEnable(ltmEnable), .coreTimeoutCal(coreTimeoutCal),
   .fsTimeoutTenths(fsTimeoutTenths), .hsTimeoutBits(hsTimeoutBits), .ready(ready)
);

// ===== tb/usb_host_model.sv
// host side model: u1 feature level and u1 entry request pulses
`timescale 1ns/100ps
module usb_host_model (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic setU1,
   input  wire logic askU1,
   output logic      hostU1Enable,
   output logic      hostU1Request
);
   // the host changes its lines only after an edge, never during reset
   always_ff @(posedge clk) begin
      hostU1Enable <= !rst && setU1;
      hostU1Request <= !rst && askU1;
   end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the link power configuration block
`timescale 1ns/100ps
module testbench;
   logic        clk, rst, wr, rd, eeP, otpP, protect, setU1, askU1, fsMode, rdq;
   logic        hostU1Enable, hostU1Request, u1Init, u1Ack, u1Reject, ltm, ready, rsn;
   logic [11:0] addr;
   logic [31:0] wdata, rdata, cfg, rnd;
   logic [5:0]  ee, otp, img;
   logic [2:0]  ev, hsCal, core;
   logic [1:0]  src;
   logic [7:0]  fsT;
   logic [9:0]  hsT;
   logic [31:0] exq[$];
   logic [1:0]  ackq[$];
   int          bad_count, n_checks;

   usb_link_power_cfg_fields uut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .eepromPresent(eeP), .eepromU1Init(ee[5]), .eepromU1Accept(ee[4]), .eepromLtm(ee[3]),
      .eepromFsCal(ee[2:0]), .otpProgrammed(otpP), .otpU1Init(otp[5]), .otpU1Accept(otp[4]),
      .otpLtm(otp[3]), .otpFsCal(otp[2:0]), .imageLoaded(ev[2]), .usbReset(ev[1]), .liteReset(ev[0]),
      .resetProtect(protect), .hostU1Enable(hostU1Enable), .hostU1Request(hostU1Request),
      .fsMode(fsMode), .hsCal(hsCal), .u1InitiateAllowed(u1Init), .u1Ack(u1Ack), .u1Reject(u1Reject),
      .ltmEnable(ltm), .coreTimeoutCal(core), .fsTimeoutTenths(fsT), .hsTimeoutBits(hsT), .ready(ready)
   );
   usb_host_model host (
      .clk(clk), .rst(rst), .setU1(setU1), .askU1(askU1),
      .hostU1Enable(hostU1Enable), .hostU1Request(hostU1Request)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] img2cfg(input logic [5:0] x);
      return {21'h0, x[5:3], 1'b0, x[2:0], 4'h0};
   endfunction
   // status word as the outputs should show it
   function automatic logic [31:0] stat();
      logic [2:0] c;
      c = fsMode ? cfg[6:4] : hsCal;
      return {8'(160 + 2 * cfg[6:4]), 2'h0, 10'(736 + 8 * hsCal), 1'h0, c, 3'h0, rsn, fsMode, cfg[10] & setU1, src};
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // one bus cycle; each call assigns every strobe once
   task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
   endtask
   task automatic idle();
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rdx(input logic [11:0] a, input logic [31:0] e);
      exq.push_back(e);
      op(1'b0, a, 32'h0);
   endtask
   // outputs trail the fields, so let them settle before the status read
   task automatic rs();
      repeat (3) idle();
      rdx(12'h0fc, stat());
   endtask
   task automatic evt(input logic [2:0] v, input logic p);
      logic [31:0] e;
      ev <= v;
      protect <= p;
      idle();
      ev <= 3'h0;
      if (v[2]) begin
         img = eeP ? ee : (otpP ? otp : 6'h10);
         src = {!eeP && otpP, eeP};
      end else begin
         e = img2cfg(img);
         cfg = p ? {21'h0, cfg[10:8], e[7:0]} : e;
         rsn = 1'b1;
      end
      idle();
   endtask

   // the answers are compared oldest note first
   always @(posedge clk) rdq <= rd;
   always @(negedge clk) begin
      if (rdq) check("rdata", rdata, exq.pop_front());
      if (!rst && (u1Ack !== 1'b0 || u1Reject !== 1'b0))
         check("u1 answer", {u1Ack, u1Reject}, ackq.pop_front());
   end

   initial begin
      repeat (3000) @(posedge clk);
      bad_count++;
      conclude();
   end

   initial begin
      rnd = 32'h8f928452;
      {wr, rd, addr, wdata, ev, protect, setU1, askU1, fsMode, hsCal} = '0;
      {rst, eeP, otpP, rsn} = 4'b1110;
      ee = rnd[5:0];
      otp = rnd[11:6];
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      img = ee;
      src = 2'b01;
      cfg = img2cfg(ee);
      for (int i = 0; i < 20 && ready !== 1'b1; i++) @(negedge clk);
      check("ready", ready, 32'h1);
      @(posedge clk);
      rdx(12'h084, cfg);
      rs();
      op(1'b1, 12'h084, 32'hffffffff);
      cfg = 32'h770;
      rdx(12'h084, cfg);
      rdx(12'h088, 32'h0);
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         setU1 <= rnd[12];
         fsMode <= rnd[13];
         hsCal <= rnd[16:14];
         op(1'b1, 12'h084, rnd);
         cfg = rnd & 32'h770;
         rdx(12'h084, cfg);
         rs();
         askU1 <= 1'b1;
         ackq.push_back({cfg[9], !cfg[9]});
         idle();
         askU1 <= 1'b0;
      end
      evt(3'b001, 1'b0);
      rdx(12'h084, cfg);
      rs();
      op(1'b1, 12'h0fc, 32'h10);
      rsn = 1'b0;
      rs();
      cfg = img2cfg(~img);
      op(1'b1, 12'h084, cfg);
      evt(3'b010, 1'b1);
      rdx(12'h084, cfg);
      for (int k = 0; k < 2; k++) begin
         {eeP, otpP} <= k ? 2'b00 : 2'b01;
         evt(3'b100, 1'b0);
         evt(3'b001, 1'b0);
         rdx(12'h084, cfg);
         rs();
      end
      repeat (3) idle();
      check("reads left", exq.size(), 32'h0);
      check("u1 answers left", ackq.size(), 32'h0);
      conclude();
   end
endmodule
